// *** cam_alu.sv ***
// 16-bit alu with 17x17 multiplier and iterative 16-bit divider
`timescale 1ns/1ps
module cam_alu (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [2:0] mul_mode,
  input wire logic byte_mode,
  input wire logic a_from_mem,
  input wire logic b_from_mem,
  input wire logic b_from_lit,
  input wire logic [3:0] a_reg,
  input wire logic [3:0] b_reg,
  input wire logic [3:0] dst_reg,
  input wire logic dst_to_mem,
  input wire logic [15:0] mem_rdata_a,
  input wire logic [15:0] mem_rdata_b,
  input wire logic [4:0] lit_val,
  input wire logic [4:0] status_wdata,
  input wire logic status_we,
  input wire logic [3:0] dbg_reg,
  output logic busy,
  output logic done,
  output logic [15:0] dbg_rdata,
  output logic mem_we,
  output logic [15:0] mem_wdata,
  output logic [4:0] status_word
);
  ////////////////////////////////////////////////////////////////////////
  logic [15:0] wreg_ff [cam_pkg::NREG];
  logic [4:0] status_ff;
  logic [4:0] nxt_status;
  cam_pkg::cam_state_e state_ff;
  logic [4:0] div_cnt_ff;
  logic [15:0] quo_ff;
  logic [16:0] rem_ff;
  logic [15:0] dvs_ff;
  logic div_qneg_ff;
  logic div_rneg_ff;
  logic [3:0] div_dst_ff;
  logic div_flag_ff;
  logic mem_we_ff;
  logic [15:0] mem_wdata_ff;
  logic done_ff;
  // zero word used as the neutral result of unused opcodes
  localparam logic [15:0] WORD0 = cam_pkg::WORD_RST;

  function automatic logic [15:0] abs16(input logic [15:0] v, input logic s);
    abs16 = (s && v[15]) ? 16'(-v) : v;
  endfunction

  // picks the sign bit for the current operand width
  function automatic logic top_bit(input logic [15:0] v, input logic bm);
    top_bit = bm ? v[7] : v[15];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // operand selection
  wire [15:0] opa = a_from_mem ? mem_rdata_a : wreg_ff[a_reg];
  wire [15:0] opb_raw = b_from_mem ? mem_rdata_b : wreg_ff[b_reg];
  wire [15:0] opb = b_from_lit ? {11'h000, lit_val} : opb_raw;
  wire is_sub = (op_code == cam_pkg::OP_SUB);
  // subtract as a + ~b + 1 so carry out is an inverted borrow
  wire [15:0] opb_eff = is_sub ? ~opb : opb;
  wire cin = is_sub;
  wire [16:0] sum_w = {1'b0, opa} + {1'b0, opb_eff} + {16'h0000, cin};
  wire [8:0] sum_b = {1'b0, opa[7:0]} + {1'b0, opb_eff[7:0]} + {8'h00, cin};
  wire [4:0] sum_n = {1'b0, opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
  wire msb_a = top_bit(opa, byte_mode);
  wire msb_b = top_bit(opb_eff, byte_mode);
  // shifts move one place only; wider shifts take several operations
  wire [15:0] sh_lsr = byte_mode ? {8'h00, 8'(opa[7:0] >> 1)} : opa >> 1;
  wire [15:0] sh_asr = byte_mode ? {8'h00, 8'($signed(opa[7:0]) >>> 1)}
                                 : 16'($signed(opa) >>> 1);

  logic [15:0] res;
  logic res_c;
  logic res_c_ok;
  logic res_arith;
  always_comb begin
    res = WORD0;
    res_c = 1'b0;
    res_c_ok = 1'b0;
    res_arith = 1'b0;
    unique case (op_code)
      cam_pkg::OP_ADD, cam_pkg::OP_SUB: begin
        res = sum_w[15:0];
        res_c = byte_mode ? sum_b[8] : sum_w[16];
        res_c_ok = 1'b1;
        res_arith = 1'b1;
      end
      cam_pkg::OP_AND: res = opa & opb;
      cam_pkg::OP_IOR: res = opa | opb;
      cam_pkg::OP_XOR: res = opa ^ opb;
      cam_pkg::OP_SHL: begin
        res = opa << 1;
        res_c = top_bit(opa, byte_mode);
        res_c_ok = 1'b1;
      end
      cam_pkg::OP_LSR: begin
        res = sh_lsr;
        res_c = opa[0];
        res_c_ok = 1'b1;
      end
      cam_pkg::OP_ASR: begin
        res = sh_asr;
        res_c = opa[0];
        res_c_ok = 1'b1;
      end
      default: res = WORD0;
    endcase
  end

  // byte results keep the upper half of a destination register untouched; a memory write carries that register's upper half
  wire [15:0] dst_old = wreg_ff[dst_reg];
  wire [15:0] res_w = byte_mode ? {dst_old[15:8], res[7:0]} : res;
  wire res_msb = top_bit(res, byte_mode);
  wire res_zero = byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);
  wire res_ovf = (msb_a == msb_b) && (res_msb != msb_a);

  always_comb begin
    nxt_status = status_ff;
    nxt_status[cam_pkg::FLG_ZERO] = res_zero;
    nxt_status[cam_pkg::FLG_NEG] = res_msb;
    if (res_c_ok) begin
      // on subtract a clear carry reads as borrow
      nxt_status[cam_pkg::FLG_CARRY] = res_c;
    end
    if (res_arith) begin
      nxt_status[cam_pkg::FLG_OVF] = res_ovf;
      nxt_status[cam_pkg::FLG_DC] = sum_n[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // multiplier operand extension picks the signedness of each side
  logic sa;
  logic sb;
  logic [16:0] ma;
  logic [16:0] mb;
  always_comb begin
    sa = 1'b0;
    sb = 1'b0;
    unique case (mul_mode)
      cam_pkg::MM_SS: begin
        sa = 1'b1;
        sb = 1'b1;
      end
      cam_pkg::MM_US: sb = 1'b1;
      cam_pkg::MM_SU: sa = 1'b1;
      cam_pkg::MM_SLIT: sa = 1'b1;
      default: sa = 1'b0;
    endcase
    ma = {sa & opa[15], opa};
    mb = {sb & opb_raw[15], opb_raw};
    if (mul_mode == cam_pkg::MM_SLIT || mul_mode == cam_pkg::MM_ULIT) begin
      mb = {12'h000, lit_val};
    end
    // byte multiply drops the upper operand bytes entirely
    if (mul_mode == cam_pkg::MM_BB) begin
      ma = {9'h000, opa[7:0]};
      mb = {9'h000, opb_raw[7:0]};
    end
  end
  logic [33:0] prod;
  cam_mul17 u_mul (
    .op_a(ma),
    .op_b(mb),
    .prod(prod)
  );
  wire is_mul = (op_code == cam_pkg::OP_MUL);
  wire is_div = (op_code == cam_pkg::OP_DIVU) || (op_code == cam_pkg::OP_DIVS);

  ////////////////////////////////////////////////////////////////////////
  // restoring divider, one quotient bit per clock over sixteen clocks
  // signs and destination are latched at start, so op_code may change
  // freely while the divider runs
  wire div_s = (op_code == cam_pkg::OP_DIVS);
  wire [16:0] rem_sh = {rem_ff[15:0], quo_ff[15]};
  wire [16:0] rem_try = rem_sh - {1'b0, dvs_ff};
  wire div_take = ~rem_try[16];
  wire div_last = (div_cnt_ff == 5'h01);
  wire [15:0] q_fin = div_qneg_ff ? 16'(-{quo_ff[14:0], div_take})
                                  : {quo_ff[14:0], div_take};
  wire [15:0] r_raw = div_take ? rem_try[15:0] : rem_sh[15:0];
  wire [15:0] r_fin = div_rneg_ff ? 16'(-r_raw) : r_raw;

  wire start = op_valid && (state_ff == cam_pkg::CAM_IDLE);
  wire alu_wr = start && !is_mul && !is_div;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= cam_pkg::CAM_IDLE;
      div_cnt_ff <= 5'h00;
      quo_ff <= cam_pkg::WORD_RST;
      rem_ff <= 17'h00000;
      dvs_ff <= cam_pkg::WORD_RST;
      div_qneg_ff <= 1'b0;
      div_rneg_ff <= 1'b0;
      div_dst_ff <= 4'h0;
      div_flag_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        cam_pkg::CAM_IDLE: begin
          if (start && is_div) begin
            state_ff <= cam_pkg::CAM_DIV;
            div_cnt_ff <= cam_pkg::DIV_STEPS;
            quo_ff <= abs16(opa, div_s);
            rem_ff <= 17'h00000;
            dvs_ff <= abs16(opb_raw, div_s);
            div_qneg_ff <= div_s && (opa[15] ^ opb_raw[15]);
            div_rneg_ff <= div_s && opa[15];
            div_dst_ff <= dst_reg;
            // a zero divisor still runs all steps; only the flag marks it
            div_flag_ff <= (opb_raw == 16'h0000);
          end
        end
        cam_pkg::CAM_DIV: begin
          quo_ff <= {quo_ff[14:0], div_take};
          rem_ff <= {1'b0, r_raw};
          div_cnt_ff <= 5'(div_cnt_ff - 5'h01);
          if (div_last) begin
            state_ff <= cam_pkg::CAM_DONE;
          end
        end
        cam_pkg::CAM_DONE: state_ff <= cam_pkg::CAM_IDLE;
        default: state_ff <= cam_pkg::CAM_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register array writes; mul writes the pair dst, dst+1
  // the pair wraps from the last register to the first
  wire [3:0] dst_hi = 4'(dst_reg + 4'h1);
  wire [3:0] div_hi = 4'(div_dst_ff + 4'h1);
  wire div_end = (state_ff == cam_pkg::CAM_DIV) && div_last;
  wire [15:0] div_q_hold = q_fin;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < cam_pkg::NREG; i++) begin
        wreg_ff[i] <= cam_pkg::WORD_RST;
      end
    end else if (start && is_mul && !dst_to_mem) begin
      wreg_ff[dst_reg] <= prod[15:0];
      wreg_ff[dst_hi] <= prod[31:16];
    end else if (alu_wr && !dst_to_mem) begin
      wreg_ff[dst_reg] <= res_w;
    end else if (div_end) begin
      wreg_ff[div_dst_ff] <= div_q_hold;
      wreg_ff[div_hi] <= r_fin;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= cam_pkg::STATUS_RST;
    end else if (alu_wr) begin
      status_ff <= nxt_status;
    end else if (div_end) begin
      status_ff[cam_pkg::FLG_ZERO] <= (q_fin == 16'h0000);
      status_ff[cam_pkg::FLG_NEG] <= q_fin[15];
      status_ff[cam_pkg::FLG_OVF] <= div_flag_ff;
    end else if (status_we) begin
      // a hardware update beats a software load in the same cycle; the
      // load is then lost, not delayed
      status_ff <= status_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mem_we_ff <= 1'b0;
      mem_wdata_ff <= cam_pkg::WORD_RST;
      done_ff <= 1'b0;
    end else begin
      // a memory write returns the low product word for multiplies
      mem_we_ff <= start && !is_div && dst_to_mem;
      mem_wdata_ff <= is_mul ? prod[15:0] : res_w;
      done_ff <= (start && !is_div) || div_end;
    end
  end

  assign busy = (state_ff != cam_pkg::CAM_IDLE);
  assign done = done_ff;
  assign mem_we = mem_we_ff;
  assign mem_wdata = mem_wdata_ff;
  assign status_word = status_ff;
  // plain mux on the array, so a write shows right after the edge that writes it
  assign dbg_rdata = wreg_ff[dbg_reg];
endmodule

// *** cam_pkg.sv ***
// constants and types shared by the alu datapath
package cam_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned MUL_W = 17;
  localparam int unsigned LIT_W = 5;
  localparam int unsigned NREG = 16;
  localparam int unsigned REG_AW = 4;
  // status_word field positions
  localparam int unsigned FLG_CARRY = 0;
  localparam int unsigned FLG_ZERO = 1;
  localparam int unsigned FLG_OVF = 2;
  localparam int unsigned FLG_NEG = 3;
  localparam int unsigned FLG_DC = 4;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [4:0] DIV_STEPS = 5'h10;
  // operation codes
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_AND = 4'h2;
  localparam logic [3:0] OP_IOR = 4'h3;
  localparam logic [3:0] OP_XOR = 4'h4;
  localparam logic [3:0] OP_SHL = 4'h5;
  localparam logic [3:0] OP_LSR = 4'h6;
  localparam logic [3:0] OP_ASR = 4'h7;
  localparam logic [3:0] OP_MUL = 4'h8;
  localparam logic [3:0] OP_DIVU = 4'h9;
  localparam logic [3:0] OP_DIVS = 4'ha;
  // multiplier modes
  localparam logic [2:0] MM_SS = 3'h0;
  localparam logic [2:0] MM_UU = 3'h1;
  localparam logic [2:0] MM_US = 3'h2;
  localparam logic [2:0] MM_SU = 3'h3;
  localparam logic [2:0] MM_SLIT = 3'h4;
  localparam logic [2:0] MM_ULIT = 3'h5;
  localparam logic [2:0] MM_BB = 3'h6;
  typedef enum logic [2:0] {
    CAM_IDLE = 3'b001,
    CAM_DIV = 3'b010,
    CAM_DONE = 3'b100
  } cam_state_e;
endpackage

// *** cam_mul17.sv ***
// signed 17x17 multiplier core
`timescale 1ns/1ps
module cam_mul17 (
  input wire logic [16:0] op_a,
  input wire logic [16:0] op_b,
  output logic [33:0] prod
);
  // operands arrive already extended; the extra bit selects signedness
  assign prod = $signed(op_a) * $signed(op_b);
endmodule

// *** cam_alu_sva.sv ***
// port assertions for the alu datapath
`timescale 1ns/1ps
module cam_alu_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic byte_mode,
  input wire logic a_from_mem,
  input wire logic b_from_mem,
  input wire logic b_from_lit,
  input wire logic dst_to_mem,
  input wire logic [15:0] mem_rdata_a,
  input wire logic [15:0] mem_rdata_b,
  input wire logic status_we,
  input wire logic busy,
  input wire logic done,
  input wire logic mem_we,
  input wire logic [15:0] mem_wdata,
  input wire logic [4:0] status_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire acc = op_valid && !busy;
  wire is_div = op_code inside {cam_pkg::OP_DIVU, cam_pkg::OP_DIVS};
  wire alu_op = op_code <= cam_pkg::OP_ASR;
  // both operands from memory, so the sum is visible at the ports
  wire mm = acc && a_from_mem && b_from_mem && !b_from_lit && dst_to_mem;
  wire [15:0] msk = byte_mode ? 16'h00ff : 16'hffff;
  chk_quick_done: assert property (acc && !is_div |=> done)
    else $error("single cycle op without done");
  chk_div_busy: assert property (
    acc && is_div |=> busy[*8] ##1 busy[*8] ##1 busy ##1 !busy)
    else $error("divider busy span wrong");
  chk_div_done: assert property (acc && is_div |-> ##[17:18] done)
    else $error("divider result late");
  chk_mem_cause: assert property (
    acc && alu_op && dst_to_mem |=> mem_we)
    else $error("result not written to memory");
  chk_mem_done: assert property (mem_we |-> done)
    else $error("memory write without done");
  chk_add_value: assert property (mm && op_code == cam_pkg::OP_ADD |=>
    (mem_wdata & $past(msk)) ==
    (($past(mem_rdata_a) + $past(mem_rdata_b)) & $past(msk)))
    else $error("sum wrong");
  chk_sub_borrow: assert property (
    mm && !byte_mode && op_code == cam_pkg::OP_SUB |=>
    status_word[0] == ($past(mem_rdata_a) >= $past(mem_rdata_b)))
    else $error("borrow flag wrong");
  chk_zero_flag: assert property (mm && alu_op |=>
    status_word[1] == ((mem_wdata & $past(msk)) == 16'h0000))
    else $error("zero flag wrong");
  chk_neg_flag: assert property (mm && alu_op && !byte_mode |=>
    status_word[3] == mem_wdata[15])
    else $error("negative flag wrong");
  chk_mul_flags: assert property (acc && op_code == cam_pkg::OP_MUL &&
    !status_we |=> $stable(status_word))
    else $error("multiply changed flags");
  cov_div: cover property (acc && is_div);
  cov_mul: cover property (acc && op_code == cam_pkg::OP_MUL);
  cov_mem: cover property (mem_we);
endmodule
bind cam_alu cam_alu_chk cam_alu_chk_i (.ref_clk, .rstn, .op_valid,
  .op_code, .byte_mode, .a_from_mem, .b_from_mem, .b_from_lit, .dst_to_mem,
  .mem_rdata_a, .mem_rdata_b, .status_we, .busy, .done, .mem_we, .mem_wdata,
  .status_word);

// *** cam_mem_model.sv ***
// data memory word on the far side of the alu
`timescale 1ns/1ps
module cam_mem_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic mem_we,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] rd_word,
  output logic [15:0] wr_count
);
  // one word deep: each stored result comes back as the next operand
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_word <= 16'h0000;
      wr_count <= 16'h0000;
    end else if (mem_we) begin
      rd_word <= mem_wdata;
      wr_count <= wr_count + 16'h0001;
    end
  end
endmodule

// *** cam_alu_tb.sv ***
// self-checking bench for the alu datapath
`timescale 1ns/1ps
module cam_alu_tb;
  logic ref_clk, rstn, op_valid, byte_mode, a_from_mem, b_from_mem;
  logic b_from_lit, dst_to_mem, status_we, busy, done, mem_we;
  logic [3:0] op_code, a_reg, b_reg, dst_reg, dbg_reg;
  logic [2:0] mul_mode;
  logic [4:0] lit_val, status_wdata, status_word;
  logic [15:0] mem_rdata_a, mem_rdata_b, dbg_rdata, mem_wdata, wr_count;
  logic [31:0] lfsr = 32'hcea1;
  int failures = 0;
  int samples_checked = 0;
  cam_alu cam_alu_i (.ref_clk, .rstn, .op_valid, .op_code, .mul_mode,
    .byte_mode, .a_from_mem, .b_from_mem, .b_from_lit, .a_reg, .b_reg,
    .dst_reg, .dst_to_mem, .mem_rdata_a, .mem_rdata_b, .lit_val,
    .status_wdata, .status_we, .dbg_reg, .busy, .done, .dbg_rdata, .mem_we,
    .mem_wdata, .status_word);
  cam_mem_model cam_mem_model_i (.ref_clk, .rstn, .mem_we, .mem_wdata,
    .rd_word(mem_rdata_b), .wr_count);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [16:0] alu_ref(logic [3:0] op, logic [15:0] a,
      logic [15:0] b, logic bm);
    logic [16:0] r;
    logic [15:0] m;
    m = bm ? 16'h00ff : 16'hffff;
    case (op)
      cam_pkg::OP_ADD: r = {1'b0, a & m} + {1'b0, b & m};
      cam_pkg::OP_SUB: r = {1'b0, a & m} + {1'b0, ~b & m} + 17'h00001;
      cam_pkg::OP_AND: r = {1'b0, a & b};
      cam_pkg::OP_IOR: r = {1'b0, a | b};
      cam_pkg::OP_SHL: r = {bm ? a[7] : a[15], a << 1};
      cam_pkg::OP_LSR: r = {a[0], (a & m) >> 1};
      cam_pkg::OP_ASR: r = {a[0], bm ? {8'h00, 8'($signed(a[7:0]) >>> 1)}
                                     : 16'($signed(a) >>> 1)};
      default: r = {1'b0, a ^ b};
    endcase
    // byte carry leaves the adder at bit eight
    if (bm && op < cam_pkg::OP_AND) r[16] = r[8];
    return {r[16], r[15:0] & m};
  endfunction
  // flags after add or subtract: digit carry, negative, overflow, zero, carry
  function automatic logic [4:0] flg_ref(logic [3:0] op, logic [15:0] a,
      logic [15:0] b, logic bm);
    logic [16:0] s;
    logic [4:0] h;
    logic sa, sb, sn;
    s = alu_ref(op, a, b, bm);
    if (op == cam_pkg::OP_SUB) b = ~b;
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, op == cam_pkg::OP_SUB};
    sa = bm ? a[7] : a[15];
    sb = bm ? b[7] : b[15];
    sn = bm ? s[7] : s[15];
    return {h[4], sn, sa == sb && sn != sa, s[15:0] == 16'h0000, s[16]};
  endfunction
  function automatic logic [31:0] mul_ref(logic [2:0] md, logic [15:0] a,
      logic [15:0] b, logic [4:0] l);
    logic sa, sb;
    logic signed [33:0] x, y;
    sa = md inside {cam_pkg::MM_SS, cam_pkg::MM_SU, cam_pkg::MM_SLIT} && a[15];
    sb = md inside {cam_pkg::MM_SS, cam_pkg::MM_US} && b[15];
    if (md inside {cam_pkg::MM_SLIT, cam_pkg::MM_ULIT}) b = {11'h000, l};
    if (md == cam_pkg::MM_BB) {a, b} = {a & 16'h00ff, b & 16'h00ff};
    x = {{18{sa}}, a};
    y = {{18{sb}}, b};
    return 32'(x * y);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic go();
    op_valid <= 1'b1;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  // register loads are an add of a memory word and a zero literal
  task automatic load(input logic [3:0] rg, input logic [15:0] v);
    @(posedge ref_clk);
    {a_from_mem, b_from_mem, b_from_lit, dst_to_mem, byte_mode} <= 5'b10100;
    {op_code, lit_val, dst_reg} <= {cam_pkg::OP_ADD, 5'h00, rg};
    mem_rdata_a <= v;
    go();
  endtask
  task automatic rd(input logic [3:0] rg, output logic [15:0] v);
    @(posedge ref_clk);
    dbg_reg <= rg;
    #1 v = dbg_rdata;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // whole run is under two thousand cycles
  initial begin
    #50000;
    failures++;
    wrap_up();
  end
  initial begin
    logic [31:0] r, e32;
    logic [16:0] e;
    logic [4:0] f;
    logic [15:0] q, m, a_w, b_w, eq, er;
    int n;
    {op_valid, byte_mode, a_from_mem, b_from_mem, b_from_lit} = '0;
    {dst_to_mem, status_we, op_code, a_reg, b_reg, dst_reg, dbg_reg} = '0;
    {mul_mode, lit_val, status_wdata, mem_rdata_a} = '0;
    rstn = 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      r = rnd();
      @(posedge ref_clk);
      {op_code, byte_mode, a_from_mem, b_from_mem, b_from_lit, dst_to_mem}
        <= {4'(i % 8), r[16], 4'b1101};
      mem_rdata_a <= (i < 8) ? 16'hffff : r[15:0];
      go();
      m = byte_mode ? 16'h00ff : 16'hffff;
      e = alu_ref(op_code, mem_rdata_a, mem_rdata_b, byte_mode);
      f = flg_ref(op_code, mem_rdata_a, mem_rdata_b, byte_mode);
      check(mem_wdata & m, e[15:0]);
      if (op_code < cam_pkg::OP_AND) check(status_word[0], e[16]);
      if (op_code < cam_pkg::OP_AND) check(status_word, f);
      if (op_code >= cam_pkg::OP_SHL) check(status_word[0], e[16]);
    end
    for (int md = 0; md < 7; md++) begin
      r = rnd();
      a_w = (md == 0) ? 16'h8000 : r[15:0];
      b_w = (md == 0) ? 16'h8000 : r[31:16];
      load(4'h1, a_w);
      load(4'h2, b_w);
      @(posedge ref_clk);
      {status_we, status_wdata} <= {1'b1, r[4:0]};
      @(posedge ref_clk);
      status_we <= 1'b0;
      {op_code, mul_mode, a_from_mem, b_from_lit, a_reg, b_reg, dst_reg,
        lit_val} <= {cam_pkg::OP_MUL, 3'(md), 10'h012, 4'(md + 9), r[20:16]};
      go();
      check(status_word, r[4:0]);
      e32 = mul_ref(3'(md), a_w, b_w, r[20:16]);
      rd(4'(md + 9), q);
      check(q, e32[15:0]);
      rd(4'(md + 10), q);
      check(q, e32[31:16]);
    end
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      {a_w, b_w} = {r[15:0], r[31:16] | 16'h0001};
      if (i == 1) {a_w, b_w} = 32'hfff90002;
      if (i == 2) {a_w, b_w} = 32'hffffffff;
      if (i == 3) b_w = 16'h0000;
      load(4'h1, a_w);
      load(4'h2, b_w);
      @(posedge ref_clk);
      {op_code, a_from_mem, b_from_lit, a_reg, b_reg, dst_reg} <=
        {i == 1 ? cam_pkg::OP_DIVS : cam_pkg::OP_DIVU, 14'h0123};
      go();
      n = wr_count;
      // an add to memory offered while dividing must be ignored
      @(posedge ref_clk);
      {op_code, dst_to_mem, op_valid} <= {cam_pkg::OP_ADD, 2'b11};
      @(posedge ref_clk);
      {dst_to_mem, op_valid} <= 2'b00;
      #1 check(busy, 1'b1);
      for (int k = 0; k < 30 && done !== 1'b1; k++) @(posedge ref_clk) #1;
      check(done, 1'b1);
      check(wr_count, 16'(n));
      if (i == 3) check(status_word[2], 1'b1);
      else begin
        eq = i == 1 ? 16'($signed(a_w) / $signed(b_w)) : a_w / b_w;
        er = i == 1 ? 16'($signed(a_w) % $signed(b_w)) : a_w % b_w;
        rd(4'h3, q);
        check(q, eq);
        rd(4'h4, q);
        check(q, er);
      end
    end
    wrap_up();
  end
endmodule
